// ===== rtl/ebt_timer.sv
// eight-bit timer channel with clock select, clear modes and axi4-lite registers
// Functional notes
// - clock-select 000 (reset value) and 100 stop the counter.
// - with divider-set bit 0, codes 001/010/011 count falling edges of clk/8, /64, /1024.
// - with divider-set bit 1, codes 001/010/011 count falling edges of clk/2, /32, /256.
// - codes 101/110/111 count external clock rising, falling or both edges, ignoring the set bit.
// - clear field 00 never clears the counter.
// - clear field 01 zeroes the counter on compare match with constant A.
// - clear field 10 zeroes the counter on compare match with constant B.
// - clear field 11 zeroes the counter on a rising edge of the external reset pin.
// - match flag A sets when count equals constant A, flag B when it equals constant B.
// - overflow interrupt is forwarded only while its enable bit 5 is 1.
// - match A and B interrupts are forwarded only while enable bits 6 and 7 are 1.
`timescale 1ns/1ps
`default_nettype none
module ebt_timer (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	input  wire logic        ext_clock_in,
	input  wire logic        ext_reset_in,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             irq
);
	logic [7:0]                   ctrl_ff, nxt_ctrl;
	logic [7:0]                   flags_ff, nxt_flags;
	logic [7:0]                   mask_ff, nxt_mask;
	logic [7:0]                   tca_ff, nxt_tca;
	logic [7:0]                   tcb_ff, nxt_tcb;
	logic [7:0]                   count_ff, nxt_count;
	logic                         sys_icks_ff, nxt_sys_icks;
	logic [ebt_pkg::PRESC_W-1:0] presc_ff, nxt_presc;
	logic [2:0]                   eclk_sync_ff, nxt_eclk_sync;
	logic [2:0]                   erst_sync_ff, nxt_erst_sync;
	logic                         irq_ff, nxt_irq;

	logic                         aw_ok_ff, nxt_aw_ok;
	logic                         w_ok_ff, nxt_w_ok;
	logic [11:0]                  awaddr_ff, nxt_awaddr;
	logic [7:0]                   wdata_ff, nxt_wdata;
	logic                         wlane_ff, nxt_wlane;
	logic                         bvalid_ff, nxt_bvalid;
	logic [1:0]                   bresp_ff, nxt_bresp;
	logic                         rvalid_ff, nxt_rvalid;
	logic [1:0]                   rresp_ff, nxt_rresp;
	logic [31:0]                  rdata_ff, nxt_rdata;
	logic                         awready_ff, nxt_awready;
	logic                         wready_ff, nxt_wready;
	logic                         arready_ff, nxt_arready;

	ebt_pkg::ebt_cnt_t            cnt;
	logic [ebt_pkg::PRESC_W-1:0] fall_tap;
	logic                         tick;
	logic                         ext_rise;
	logic                         ext_fall;
	logic                         erst_rise;
	logic                         do_write;
	logic [2:0]                   cks;
	logic [1:0]                   cclr;

	assign cks  = ctrl_ff[ebt_pkg::CTRL_CKS_LSB +: 3];
	assign cclr = ctrl_ff[ebt_pkg::CTRL_CCLR_LSB +: 2];

	// a prescaler bit falling from 1 to 0 marks the falling edge of clk/2^(n+1)
	genvar g;
	generate
		for (g = 0; g < ebt_pkg::PRESC_W; g++) begin : g_tap
			assign fall_tap[g] = presc_ff[g] & ~nxt_presc[g];
		end
	endgenerate

	// stage 0 only feeds stage 1; edges are taken between stages 1 and 2
	assign ext_rise  = eclk_sync_ff[1] & ~eclk_sync_ff[2];
	assign ext_fall  = ~eclk_sync_ff[1] & eclk_sync_ff[2];
	assign erst_rise = erst_sync_ff[1] & ~erst_sync_ff[2];

	always_comb begin
		nxt_presc     = presc_ff + 1'b1;
		nxt_eclk_sync = {eclk_sync_ff[1:0], ext_clock_in};
		nxt_erst_sync = {erst_sync_ff[1:0], ext_reset_in};
	end

	always_comb begin
		case (cks)
			ebt_pkg::CKS_STOP0: tick = 1'b0;
			ebt_pkg::CKS_STOP4: tick = 1'b0;
			ebt_pkg::CKS_DIV_A: tick = sys_icks_ff ? fall_tap[ebt_pkg::TAP_2]
							: fall_tap[ebt_pkg::TAP_8];
			ebt_pkg::CKS_DIV_B: tick = sys_icks_ff ? fall_tap[ebt_pkg::TAP_32]
							: fall_tap[ebt_pkg::TAP_64];
			ebt_pkg::CKS_DIV_C: tick = sys_icks_ff ? fall_tap[ebt_pkg::TAP_256]
							: fall_tap[ebt_pkg::TAP_1024];
			ebt_pkg::CKS_EXT_R: tick = ext_rise;
			ebt_pkg::CKS_EXT_F: tick = ext_fall;
			ebt_pkg::CKS_EXT_B: tick = ext_rise | ext_fall;
			default:            tick = 1'b0;
		endcase
	end

	// compare is continuous on the current count, so a held match sets the flag again every cycle, even right after a clear
	always_comb begin
		cnt.count   = count_ff;
		cnt.match_a = (count_ff == tca_ff);
		cnt.match_b = (count_ff == tcb_ff);
		cnt.wrap    = tick && (count_ff == ebt_pkg::COUNT_MAX);
	end

	assign do_write = aw_ok_ff && w_ok_ff && !bvalid_ff;

	always_comb begin
		nxt_ctrl     = ctrl_ff;
		nxt_mask     = mask_ff;
		nxt_tca      = tca_ff;
		nxt_tcb      = tcb_ff;
		nxt_sys_icks = sys_icks_ff;
		nxt_flags    = flags_ff;
		nxt_count    = count_ff;
		if (tick)
			nxt_count = count_ff + 8'h01;
		case (cclr)
			ebt_pkg::CCLR_NONE: ;
			ebt_pkg::CCLR_MA: if (cnt.match_a) nxt_count = ebt_pkg::COUNT_RESET;
			ebt_pkg::CCLR_MB: if (cnt.match_b) nxt_count = ebt_pkg::COUNT_RESET;
			ebt_pkg::CCLR_EXT: if (erst_rise) nxt_count = ebt_pkg::COUNT_RESET;
			default: ;
		endcase
		if (do_write && wlane_ff) begin
			case (awaddr_ff)
				ebt_pkg::ADDR_CTRL:   nxt_ctrl = wdata_ff;
				ebt_pkg::ADDR_MASK:   nxt_mask = wdata_ff;
				ebt_pkg::ADDR_TCA:    nxt_tca = wdata_ff;
				ebt_pkg::ADDR_TCB:    nxt_tcb = wdata_ff;
				ebt_pkg::ADDR_COUNT:  nxt_count = wdata_ff;
				ebt_pkg::ADDR_SYSCFG: nxt_sys_icks = wdata_ff[ebt_pkg::SYS_ICKS];
				ebt_pkg::ADDR_STAT:   nxt_flags = flags_ff & wdata_ff;
				default: ;
			endcase
		end
		// hardware set wins over a same-cycle clear
		if (cnt.match_a) nxt_flags[ebt_pkg::FLAG_MATCH_A] = 1'b1;
		if (cnt.match_b) nxt_flags[ebt_pkg::FLAG_MATCH_B] = 1'b1;
		if (cnt.wrap) nxt_flags[ebt_pkg::FLAG_OVERFLOW] = 1'b1;
		nxt_flags[4:0] = 5'h00;
	end

	// both the channel enable and the extra mask must be open
	always_comb begin
		nxt_irq = (flags_ff[ebt_pkg::FLAG_OVERFLOW] & ctrl_ff[ebt_pkg::CTRL_OVERFLOW_EN]
				& mask_ff[ebt_pkg::FLAG_OVERFLOW])
			| (flags_ff[ebt_pkg::FLAG_MATCH_A] & ctrl_ff[ebt_pkg::CTRL_MATCH_A_EN]
				& mask_ff[ebt_pkg::FLAG_MATCH_A])
			| (flags_ff[ebt_pkg::FLAG_MATCH_B] & ctrl_ff[ebt_pkg::CTRL_MATCH_B_EN]
				& mask_ff[ebt_pkg::FLAG_MATCH_B]);
	end

	// write channel: address and data latched independently, response after both
	always_comb begin
		nxt_aw_ok  = aw_ok_ff;
		nxt_w_ok   = w_ok_ff;
		nxt_awaddr = awaddr_ff;
		nxt_wdata  = wdata_ff;
		nxt_wlane  = wlane_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp  = bresp_ff;
		if (s_axi_awvalid && !aw_ok_ff) begin
			nxt_aw_ok  = 1'b1;
			nxt_awaddr = {s_axi_awaddr[11:2], 2'h0};
		end
		if (s_axi_wvalid && !w_ok_ff) begin
			nxt_w_ok  = 1'b1;
			nxt_wdata = s_axi_wdata[7:0];
			nxt_wlane = s_axi_wstrb[0];
		end
		if (do_write) begin
			nxt_aw_ok  = 1'b0;
			nxt_w_ok   = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp  = (awaddr_ff <= ebt_pkg::ADDR_SYSCFG) ? ebt_pkg::RESP_OKAY
									: ebt_pkg::RESP_SLVERR;
		end else if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		nxt_awready = ~nxt_aw_ok;
		nxt_wready  = ~nxt_w_ok;
	end

	always_comb begin
		nxt_rvalid = rvalid_ff;
		nxt_rresp  = rresp_ff;
		nxt_rdata  = rdata_ff;
		if (s_axi_arvalid && !rvalid_ff) begin
			nxt_rvalid = 1'b1;
			nxt_rresp  = ebt_pkg::RESP_OKAY;
			case ({s_axi_araddr[11:2], 2'h0})
				ebt_pkg::ADDR_CTRL:   nxt_rdata = {24'h000000, ctrl_ff};
				ebt_pkg::ADDR_STAT:   nxt_rdata = {24'h000000, flags_ff};
				ebt_pkg::ADDR_MASK:   nxt_rdata = {24'h000000, mask_ff};
				ebt_pkg::ADDR_TCA:    nxt_rdata = {24'h000000, tca_ff};
				ebt_pkg::ADDR_TCB:    nxt_rdata = {24'h000000, tcb_ff};
				ebt_pkg::ADDR_COUNT:  nxt_rdata = {24'h000000, cnt.count};
				ebt_pkg::ADDR_SYSCFG: nxt_rdata = {31'h00000000, sys_icks_ff};
				ebt_pkg::ADDR_IRQ:    nxt_rdata = {31'h00000000, irq_ff};
				default: begin
					nxt_rdata = 32'h00000000;
					nxt_rresp = ebt_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
		nxt_arready = ~nxt_rvalid;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_ff      <= ebt_pkg::CTRL_RESET;
			flags_ff     <= 8'h00;
			mask_ff      <= ebt_pkg::MASK_RESET;
			tca_ff       <= ebt_pkg::TC_RESET;
			tcb_ff       <= ebt_pkg::TC_RESET;
			count_ff     <= ebt_pkg::COUNT_RESET;
			sys_icks_ff  <= 1'b0;
			presc_ff     <= '0;
			eclk_sync_ff <= 3'h0;
			erst_sync_ff <= 3'h0;
			irq_ff       <= 1'b0;
			aw_ok_ff     <= 1'b0;
			w_ok_ff      <= 1'b0;
			awaddr_ff    <= 12'h000;
			wdata_ff     <= 8'h00;
			wlane_ff     <= 1'b0;
			bvalid_ff    <= 1'b0;
			bresp_ff     <= ebt_pkg::RESP_OKAY;
			rvalid_ff    <= 1'b0;
			rresp_ff     <= ebt_pkg::RESP_OKAY;
			rdata_ff     <= 32'h00000000;
			awready_ff   <= 1'b1;
			wready_ff    <= 1'b1;
			arready_ff   <= 1'b1;
		end else if (clk_en) begin
			ctrl_ff      <= nxt_ctrl;
			flags_ff     <= nxt_flags;
			mask_ff      <= nxt_mask;
			tca_ff       <= nxt_tca;
			tcb_ff       <= nxt_tcb;
			count_ff     <= nxt_count;
			sys_icks_ff  <= nxt_sys_icks;
			presc_ff     <= nxt_presc;
			eclk_sync_ff <= nxt_eclk_sync;
			erst_sync_ff <= nxt_erst_sync;
			irq_ff       <= nxt_irq;
			aw_ok_ff     <= nxt_aw_ok;
			w_ok_ff      <= nxt_w_ok;
			awaddr_ff    <= nxt_awaddr;
			wdata_ff     <= nxt_wdata;
			wlane_ff     <= nxt_wlane;
			bvalid_ff    <= nxt_bvalid;
			bresp_ff     <= nxt_bresp;
			rvalid_ff    <= nxt_rvalid;
			rresp_ff     <= nxt_rresp;
			rdata_ff     <= nxt_rdata;
			awready_ff   <= nxt_awready;
			wready_ff    <= nxt_wready;
			arready_ff   <= nxt_arready;
		end
	end

	// ready flops mirror the inverse of the held flags, so no gate sits on a port
	always_comb begin
		s_axi_awready = awready_ff;
		s_axi_wready  = wready_ff;
		s_axi_bvalid  = bvalid_ff;
		s_axi_bresp   = bresp_ff;
		s_axi_arready = arready_ff;
		s_axi_rvalid  = rvalid_ff;
		s_axi_rresp   = rresp_ff;
		s_axi_rdata   = rdata_ff;
		irq           = irq_ff;
	end
endmodule
`default_nettype wire

// ===== rtl/ebt_pkg.sv
// package for the eight-bit timer channel: register map, fields, reset values
package ebt_pkg;
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_STAT   = 12'h004;
	localparam logic [11:0] ADDR_MASK   = 12'h008;
	localparam logic [11:0] ADDR_TCA    = 12'h00C;
	localparam logic [11:0] ADDR_TCB    = 12'h010;
	localparam logic [11:0] ADDR_COUNT  = 12'h014;
	localparam logic [11:0] ADDR_SYSCFG = 12'h018;
	localparam logic [11:0] ADDR_IRQ    = 12'h01C;

	localparam int CTRL_CKS_LSB  = 0;
	localparam int CTRL_CCLR_LSB = 3;
	localparam int CTRL_OVERFLOW_EN = 5;
	localparam int CTRL_MATCH_A_EN  = 6;
	localparam int CTRL_MATCH_B_EN  = 7;
	localparam int FLAG_OVERFLOW    = 5;
	localparam int FLAG_MATCH_A     = 6;
	localparam int FLAG_MATCH_B     = 7;
	localparam int SYS_ICKS      = 0;

	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [7:0] TC_RESET    = 8'hFF;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET  = 8'h00;
	localparam logic [7:0] COUNT_MAX   = 8'hFF;

	localparam logic [2:0] CKS_STOP0 = 3'h0;
	localparam logic [2:0] CKS_DIV_A = 3'h1;
	localparam logic [2:0] CKS_DIV_B = 3'h2;
	localparam logic [2:0] CKS_DIV_C = 3'h3;
	localparam logic [2:0] CKS_STOP4 = 3'h4;
	localparam logic [2:0] CKS_EXT_R = 3'h5;
	localparam logic [2:0] CKS_EXT_F = 3'h6;
	localparam logic [2:0] CKS_EXT_B = 3'h7;

	localparam logic [1:0] CCLR_NONE  = 2'h0;
	localparam logic [1:0] CCLR_MA    = 2'h1;
	localparam logic [1:0] CCLR_MB    = 2'h2;
	localparam logic [1:0] CCLR_EXT   = 2'h3;

	// prescaler tap indices: divide-by-2^n, falling edge of bit n-1
	localparam int TAP_2    = 0;
	localparam int TAP_8    = 2;
	localparam int TAP_32   = 4;
	localparam int TAP_64   = 5;
	localparam int TAP_256  = 7;
	localparam int TAP_1024 = 9;
	localparam int PRESC_W  = 10;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [7:0] count;
		logic       match_a;
		logic       match_b;
		logic       wrap;
	} ebt_cnt_t;
endpackage

// ===== testbench/ebt_timer_checker.sv
// port-level checks of bus handshakes and interrupt gating for the timer
`timescale 1ns/1ps
`default_nettype none
module ebt_timer_checker (
	input wire logic	clk,
	input wire logic	reset_n,
	input wire logic	clk_en,
	input wire logic [11:0]	s_axi_awaddr,
	input wire logic	s_axi_awvalid,
	input wire logic	s_axi_awready,
	input wire logic [31:0]	s_axi_wdata,
	input wire logic	s_axi_wvalid,
	input wire logic	s_axi_wready,
	input wire logic [1:0]	s_axi_bresp,
	input wire logic	s_axi_bvalid,
	input wire logic	s_axi_bready,
	input wire logic	s_axi_arvalid,
	input wire logic	s_axi_arready,
	input wire logic [31:0]	s_axi_rdata,
	input wire logic	s_axi_rvalid,
	input wire logic	s_axi_rready,
	input wire logic	irq
);
	// shadow of enables; only same-cycle address and data are tracked
	logic [2:0]	en_ff, nxt_en, mk_ff, nxt_mk;
	logic		wr_go, en_off;
	assign wr_go = clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign en_off = (en_ff & mk_ff) == 3'h0;
	always_comb begin
		nxt_en = en_ff;
		nxt_mk = mk_ff;
		if (wr_go && s_axi_awaddr == ebt_pkg::ADDR_CTRL)
			nxt_en = s_axi_wdata[7:5];
		if (wr_go && s_axi_awaddr == ebt_pkg::ADDR_MASK)
			nxt_mk = s_axi_wdata[7:5];
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			en_ff <= 3'h0;
			mk_ff <= 3'h0;
		end else begin
			en_ff <= nxt_en;
			mk_ff <= nxt_mk;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	wr_answer_a: assert property (wr_go ##1 clk_en |=> s_axi_bvalid)
		else $error("write answer late");
	rd_answer_a: assert property (clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	wr_unmapped_a: assert property (wr_go && s_axi_awaddr > ebt_pkg::ADDR_SYSCFG ##1 clk_en
		|=> s_axi_bresp == ebt_pkg::RESP_SLVERR) else $error("unmapped write accepted");
	rd_lane_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	irq_gate_a: assert property (en_off [*3] |-> !irq)
		else $error("interrupt while disabled");
endmodule
bind ebt_timer ebt_timer_checker chk_i (
	.clk           (clk),
	.reset_n       (reset_n),
	.clk_en        (clk_en),
	.s_axi_awaddr  (s_axi_awaddr),
	.s_axi_awvalid (s_axi_awvalid),
	.s_axi_awready (s_axi_awready),
	.s_axi_wdata   (s_axi_wdata),
	.s_axi_wvalid  (s_axi_wvalid),
	.s_axi_wready  (s_axi_wready),
	.s_axi_bresp   (s_axi_bresp),
	.s_axi_bvalid  (s_axi_bvalid),
	.s_axi_bready  (s_axi_bready),
	.s_axi_arvalid (s_axi_arvalid),
	.s_axi_arready (s_axi_arready),
	.s_axi_rdata   (s_axi_rdata),
	.s_axi_rvalid  (s_axi_rvalid),
	.s_axi_rready  (s_axi_rready),
	.irq           (irq)
);
`default_nettype wire

// ===== testbench/ebt_pins_model.sv
// far side of the timer: external count clock and counter reset pins
`timescale 1ns/1ps
`default_nettype none
module ebt_pins_model (
	input wire logic	clk,
	output var logic	ext_clock_in,
	output var logic	ext_reset_in
);
	// pins start low; between bursts the reset pin rests low and the clock pin rests high
	initial begin
		ext_clock_in = 1'h0;
		ext_reset_in = 1'h0;
	end
	// each level lasts hold+1 clocks, never under the two-clock minimum
	task automatic clock_level(input logic l, input int hold);
		@(posedge clk);
		ext_clock_in <= l;
		repeat (hold) @(posedge clk);
	endtask
	task automatic clock_pulses(input int n, input int hold);
		repeat (n) begin
			clock_level(1'h1, hold);
			clock_level(1'h0, hold);
		end
	endtask
	task automatic reset_pulse(input int hold);
		@(posedge clk);
		ext_reset_in <= 1'h1;
		repeat (hold) @(posedge clk);
		ext_reset_in <= 1'h0;
		repeat (hold) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// ===== testbench/test_eight_bit_timer_control.sv
// self-checking bench: bus tasks, pin stimulus and a reference count model
`timescale 1ns/1ps
`default_nettype none
module test_eight_bit_timer_control;
	localparam logic [11:0] CT = ebt_pkg::ADDR_CTRL;
	localparam logic [11:0] CN = ebt_pkg::ADDR_COUNT;
	localparam logic [11:0] ST = ebt_pkg::ADDR_STAT;
	logic clk = 1'h0, reset_n = 1'h0, clk_en = 1'h1, ext_clock_in, ext_reset_in, irq;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int err_total = 0, checked = 0, cycles = 0, k, dv, n, ok, ticks;
	integer seed = 32'hE7657DA5;
	logic [33:0] v;
	logic [7:0] cnt, en, mk, fl;
	logic [7:0] rst_tab [8] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
	int div_tab [2][3] = '{'{8, 64, 1024}, '{2, 32, 256}};
	logic [2:0] cs_tab [6] = '{3'h5, 3'h6, 3'h7, 3'h5, 3'h4, 3'h0};
	ebt_timer uut (
		.clk           (clk),
		.reset_n       (reset_n),
		.clk_en        (clk_en),
		.ext_clock_in  (ext_clock_in),
		.ext_reset_in  (ext_reset_in),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.irq           (irq)
	);
	ebt_pins_model pins (.clk(clk), .ext_clock_in(ext_clock_in), .ext_reset_in(ext_reset_in));
	always #5 clk = ~clk;
	// slowest divider pass needs up to about 5120 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			err_total++;
			test_done();
		end
	end
	task automatic test_done;
		$display("totals: %0d checks, %0d wrong", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input bit w, input logic [11:0] a, input logic [7:0] d,
		output logic [33:0] r);
		bit done;
		done = 1'h0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		while (!done) begin
			@(posedge clk);
			if (s_axi_awready === 1'h1)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1)
				s_axi_wvalid <= 1'h0;
			if (s_axi_arready === 1'h1)
				s_axi_arvalid <= 1'h0;
			done = w ? s_axi_bvalid === 1'h1 : s_axi_rvalid === 1'h1;
			r = w ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
		end
		s_axi_bready <= 1'h0;
		s_axi_rready <= 1'h0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		bus(1'h1, a, d, v);
		chk(v, 34'h0);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		reset_n <= 1'h1;
		for (int i = 0; i < 9; i++) begin
			bus(1'h0, 12'(4 * i), 8'h00, v);
			chk(v, (i == 8) ? {ebt_pkg::RESP_SLVERR, 32'h0} : {26'h0, rst_tab[i]});
		end
		bus(1'h1, ebt_pkg::ADDR_IRQ, 8'h01, v);
		chk(v, {ebt_pkg::RESP_SLVERR, 32'h0});
		$display("test done: reset values");
		for (int s = 0; s < 2; s++) begin
			for (int c = 1; c < 4; c++) begin
				k = 2 + $unsigned($random(seed)) % 4;
				dv = div_tab[s][c - 1];
				wr(CN, 8'h00);
				wr(ebt_pkg::ADDR_SYSCFG, 8'(s));
				wr(CT, 8'(c));
				repeat (dv * k) @(posedge clk);
				wr(CT, 8'h00);
				bus(1'h0, CN, 8'h00, v);
				ok = 0;
				// bus overhead adds a few enabled cycles at the fast rates
				for (int j = k - 1; j <= k + 1 + 8 / dv; j++)
					if (v === {26'h0, 8'(j)})
						ok = 1;
				chk(34'(ok), 34'h1);
			end
		end
		// low enable freezes prescaler and counter: four enabled edges at /2 give two ticks
		wr(CN, 8'h00);
		wr(CT, 8'h01);
		clk_en <= 1'h0;
		repeat (50) @(posedge clk);
		clk_en <= 1'h1;
		wr(CT, 8'h00);
		bus(1'h0, CN, 8'h00, v);
		chk(v, {26'h0, 8'h02});
		$display("test done: internal dividers");
		wr(ebt_pkg::ADDR_TCA, 8'h03);
		wr(ebt_pkg::ADDR_TCB, 8'h05);
		for (int m = 0; m < 6; m++) begin
			n = 4 + $unsigned($random(seed)) % 3;
			en = 8'($random(seed));
			mk = 8'($random(seed));
			cnt = (m > 0 && m < 4) ? 8'h00 : 8'hFC;
			fl = 8'h00;
			pins.clock_level(1'h0, 2);
			wr(CT, 8'h00);
			wr(CN, cnt);
			wr(ST, 8'h00);
			wr(ebt_pkg::ADDR_MASK, mk);
			wr(CT, {en[7:5], 2'((m < 4) ? m : 0), cs_tab[m]});
			pins.clock_pulses(n, 2 + $unsigned($random(seed)) % 3);
			pins.clock_level(1'h1, 2);
			pins.reset_pulse(3);
			ticks = (cs_tab[m] == 3'h5) ? n + 1 : (cs_tab[m] == 3'h6) ? n :
				(cs_tab[m] == 3'h7) ? 2 * n + 1 : 0;
			repeat (ticks) begin
				cnt++;
				fl[5] |= cnt == 8'h00;
				fl[6] |= cnt == 8'h03;
				fl[7] |= cnt == 8'h05;
				if ((m == 1 && cnt == 8'h03) || (m == 2 && cnt == 8'h05))
					cnt = 8'h00;
			end
			if (m == 3)
				cnt = 8'h00;
			bus(1'h0, CN, 8'h00, v);
			chk(v, {26'h0, cnt});
			for (int p = 0; p < 3; p++) begin
				if (p == 1)
					wr(ST, 8'hE0);
				if (p == 2) begin
					wr(ST, 8'h00);
					fl = {cnt == 8'h05, cnt == 8'h03, 6'h00};
				end
				bus(1'h0, ST, 8'h00, v);
				chk(v, {26'h0, fl});
				chk({33'h0, irq}, {33'h0, |(fl & en & mk)});
			end
		end
		$display("test done: external clock and clear modes");
		test_done();
	end
endmodule
`default_nettype wire
